// ---- hdl/charger_sysmin_input_limit_regs.sv ----
// Operation
// RULE1 - Floor voltage 1.024 to 16.128 V, 256 mV
// RULE2 - Out-of-range floor writes are dropped
// RULE3 - Floor reset value follows cell count pin
// RULE4 - Floor field bits 13:8, 8192 to 256 mV
// RULE5 - Bits 15:14 reset zero, set means invalid
// RULE6 - Low byte ignored, resets to zero
// RULE7 - Linear below floor, full on above
// RULE8 - Switch off: system 160 mV above battery
// RULE9 - Host enters high impedance, clears enables
// RULE10 - Host checks voltage, sets current, exits
// RULE11 - High impedance while pin low or bit
// RULE12 - Host sets low limit leaving high impedance
// RULE13 - Input limit 50 to 6400 mA, 50 mA
// RULE14 - Limit defaults 3.3 A, reloads on removal
// RULE15 - Limit code zero means 50 mA
// RULE16 - Limit value is a ceiling
// RULE17 - Throttle charge on overcurrent or undervoltage
// RULE18 - Limit pin unused by bit or 4 V
// RULE19 - Linear enable resets to one
// RULE20 - Word write and read by command code
module charger_sysmin_input_limit_regs (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [7:0] cmd_in,
	input wire logic [15:0] wr_data_in,
	input wire logic wr_strobe_in,
	input wire logic rd_strobe_in,
	input wire charger_regs_pkg::pin_in_t pins_in,
	output logic [15:0] rd_data_out,
	output logic rd_valid_out,
	output logic [15:0] floor_voltage_out,
	output logic [12:0] input_ceiling_ma_out,
	output charger_regs_pkg::regulation_t regulation_out
);

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic floor_write_ok(input logic [15:0] data);
		logic [5:0] code;
		code = data[charger_regs_pkg::FLOOR_MSB:charger_regs_pkg::FIELD_LSB];
		// Top code is exactly 16.128 V, so only the lower bound needs a compare
		floor_write_ok = (data[15:14] == 2'h0) && (code >= charger_regs_pkg::FLOOR_CODE_MIN); // see RULE1
	endfunction

	function automatic logic [15:0] floor_by_cells(input logic [1:0] cells);
		case (cells)
			2'h0: floor_by_cells = charger_regs_pkg::FLOOR_RST_1S;
			2'h1: floor_by_cells = charger_regs_pkg::FLOOR_RST_2S;
			2'h2: floor_by_cells = charger_regs_pkg::FLOOR_RST_3S;
			default: floor_by_cells = charger_regs_pkg::FLOOR_RST_4S;
		endcase
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	charger_regs_pkg::pin_in_t sync1_reg, sync2_reg, sync3_reg, pins_reg, pins_next;

	always_comb begin
		pins_next = pins_reg;
		// Pins settle only when two stages agree, filtering a single metastable sample
		for (int i = 0; i < $bits(pins_next); i++) begin
			if (sync2_reg[i] == sync3_reg[i]) begin
				pins_next[i] = sync3_reg[i];
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			pins_reg <= '0;
		end else begin
			sync1_reg <= pins_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			pins_reg <= pins_next;
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	logic [15:0] floor_reg, floor_next;
	logic [6:0] limit_code_reg, limit_code_next;
	logic linear_en_reg, linear_en_next;
	logic wake_en_reg, wake_en_next;
	logic pin_dis_reg, pin_dis_next;
	logic hiz_bit_reg, hiz_bit_next;
	logic [2:0] settle_reg, settle_next;
	logic adapter_seen_reg, adapter_seen_next;
	logic [15:0] rd_data_reg, rd_data_next;
	logic rd_valid_reg, rd_valid_next;

	always_comb begin
		floor_next = floor_reg;
		limit_code_next = limit_code_reg;
		linear_en_next = linear_en_reg;
		wake_en_next = wake_en_reg;
		pin_dis_next = pin_dis_reg;
		hiz_bit_next = hiz_bit_reg;
		settle_next = settle_reg;
		adapter_seen_next = pins_reg.adapter_present;
		rd_valid_next = rd_strobe_in;
		rd_data_next = rd_data_reg;
		// Strap is caught after release, once the synchroniser has filled
		if (settle_reg != charger_regs_pkg::SETTLE_CYCLES) begin
			// Third stage must agree with the second before the strap counts
			settle_next = 3'(settle_reg + 3'h1);
			if (settle_next == charger_regs_pkg::SETTLE_CYCLES) begin
				floor_next = floor_by_cells(pins_next.cell_count); // see RULE3
			end
		end
		if (wr_strobe_in) begin // see RULE20
			if (cmd_in == charger_regs_pkg::CMD_FLOOR) begin
				if (floor_write_ok(wr_data_in)) begin // see RULE2 see RULE5
					floor_next = {2'h0, wr_data_in[13:8], 8'h00}; // see RULE4 see RULE6
				end
			end else if (cmd_in == charger_regs_pkg::CMD_HOST_LIMIT) begin
				if (!wr_data_in[15]) begin // see RULE13
					limit_code_next =
						wr_data_in[charger_regs_pkg::LIMIT_MSB:charger_regs_pkg::FIELD_LSB];
				end
			end else if (cmd_in == charger_regs_pkg::CMD_LINEAR_CFG) begin
				linear_en_next = wr_data_in[charger_regs_pkg::LINEAR_EN_BIT];
			end else if (cmd_in == charger_regs_pkg::CMD_WAKE_CFG) begin
				wake_en_next = wr_data_in[charger_regs_pkg::WAKE_EN_BIT];
			end else if (cmd_in == charger_regs_pkg::CMD_PIN_CFG) begin
				pin_dis_next = wr_data_in[charger_regs_pkg::PIN_DIS_BIT]; // see RULE18
			end else if (cmd_in == charger_regs_pkg::CMD_HIZ_CFG) begin
				hiz_bit_next = wr_data_in[charger_regs_pkg::HIZ_BIT]; // see RULE11
			end
		end
		// Removal wins over a host write in the same cycle
		if (adapter_seen_reg && !pins_reg.adapter_present) begin
			limit_code_next = charger_regs_pkg::HOST_LIMIT_RST[14:8]; // see RULE14
		end
		if (rd_strobe_in) begin // see RULE20
			rd_data_next = 16'h0000;
			if (cmd_in == charger_regs_pkg::CMD_FLOOR) begin
				rd_data_next = floor_reg;
			end else if (cmd_in == charger_regs_pkg::CMD_HOST_LIMIT) begin
				rd_data_next = {1'h0, limit_code_reg, 8'h00};
			end else if (cmd_in == charger_regs_pkg::CMD_LINEAR_CFG) begin
				rd_data_next[charger_regs_pkg::LINEAR_EN_BIT] = linear_en_reg;
			end else if (cmd_in == charger_regs_pkg::CMD_WAKE_CFG) begin
				rd_data_next[charger_regs_pkg::WAKE_EN_BIT] = wake_en_reg;
			end else if (cmd_in == charger_regs_pkg::CMD_PIN_CFG) begin
				rd_data_next[charger_regs_pkg::PIN_DIS_BIT] = pin_dis_reg;
			end else if (cmd_in == charger_regs_pkg::CMD_HIZ_CFG) begin
				rd_data_next[charger_regs_pkg::HIZ_BIT] = hiz_bit_reg;
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			floor_reg <= charger_regs_pkg::FLOOR_RST_1S;
			limit_code_reg <= charger_regs_pkg::HOST_LIMIT_RST[14:8]; // see RULE14
			linear_en_reg <= charger_regs_pkg::LINEAR_EN_RST; // see RULE19
			wake_en_reg <= charger_regs_pkg::WAKE_EN_RST;
			pin_dis_reg <= charger_regs_pkg::PIN_DIS_RST;
			hiz_bit_reg <= charger_regs_pkg::HIZ_RST;
			settle_reg <= 3'h0;
			adapter_seen_reg <= 1'h0;
			rd_data_reg <= 16'h0000;
			rd_valid_reg <= 1'h0;
		end else begin
			floor_reg <= floor_next;
			limit_code_reg <= limit_code_next;
			linear_en_reg <= linear_en_next;
			wake_en_reg <= wake_en_next;
			pin_dis_reg <= pin_dis_next;
			hiz_bit_reg <= hiz_bit_next;
			settle_reg <= settle_next;
			adapter_seen_reg <= adapter_seen_next;
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	// ****************************************
	// Regulation mode selection
	// ****************************************
	charger_regs_pkg::regulation_t reg_mode_reg, reg_mode_next;
	logic [12:0] ceiling_reg, ceiling_next;

	always_comb begin
		reg_mode_next.limit_pin_enable = !pin_dis_reg && !pins_reg.limit_pin_above_4v; // see RULE18
		reg_mode_next.high_impedance_state = hiz_bit_reg ||
			(reg_mode_next.limit_pin_enable && pins_reg.limit_pin_low); // see RULE11
		reg_mode_next.switch_linear = linear_en_reg && pins_reg.batt_below_floor; // see RULE7
		reg_mode_next.switch_full_on = !pins_reg.batt_below_floor &&
			(pins_reg.charging || pins_reg.supplementing); // see RULE7
		// Without linear mode the switch is simply off below the floor
		reg_mode_next.sys_above_batt_160mv = !reg_mode_next.switch_linear &&
			!reg_mode_next.switch_full_on; // see RULE8
		reg_mode_next.charge_throttle = pins_reg.input_over_limit ||
			pins_reg.input_under_voltage; // see RULE17
		// Ceiling, not typical: loops regulate at or below this figure
		ceiling_next = 13'(limit_code_reg * charger_regs_pkg::LIMIT_STEP_MA
			+ charger_regs_pkg::LIMIT_OFFSET_MA); // see RULE15 see RULE16
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			reg_mode_reg <= '0;
			ceiling_reg <= 13'h0000;
		end else begin
			reg_mode_reg <= reg_mode_next;
			ceiling_reg <= ceiling_next;
		end
	end

	assign rd_data_out = rd_data_reg;
	assign rd_valid_out = rd_valid_reg;
	assign floor_voltage_out = floor_reg;
	assign input_ceiling_ma_out = ceiling_reg;
	assign regulation_out = reg_mode_reg;

endmodule // charger_sysmin_input_limit_regs

// ---- hdl/charger_regs_pkg.sv ----
package charger_regs_pkg;

	// ****************************************
	// Command codes and bit positions
	// ****************************************
	localparam logic [7:0] CMD_LINEAR_CFG = 8'h12;
	localparam logic [7:0] CMD_WAKE_CFG = 8'h30;
	localparam logic [7:0] CMD_PIN_CFG = 8'h31;
	localparam logic [7:0] CMD_HIZ_CFG = 8'h32;
	localparam logic [7:0] CMD_FLOOR = 8'h3E;
	localparam logic [7:0] CMD_HOST_LIMIT = 8'h3F;

	localparam int LINEAR_EN_BIT = 2;
	localparam int WAKE_EN_BIT = 0;
	localparam int PIN_DIS_BIT = 7;
	localparam int HIZ_BIT = 15;
	localparam int FIELD_LSB = 8;
	localparam int FLOOR_MSB = 13;
	localparam int LIMIT_MSB = 14;

	// ****************************************
	// Reset values and limits
	// ****************************************
	localparam logic [5:0] FLOOR_CODE_MIN = 6'h04;
	localparam logic [15:0] FLOOR_RST_1S = 16'h0E00;
	localparam logic [15:0] FLOOR_RST_2S = 16'h1800;
	localparam logic [15:0] FLOOR_RST_3S = 16'h2400;
	localparam logic [15:0] FLOOR_RST_4S = 16'h3000;
	localparam logic [15:0] HOST_LIMIT_RST = 16'h4100;
	localparam logic LINEAR_EN_RST = 1'h1;
	localparam logic WAKE_EN_RST = 1'h1;
	localparam logic PIN_DIS_RST = 1'h0;
	localparam logic HIZ_RST = 1'h0;
	localparam logic [12:0] LIMIT_STEP_MA = 13'h0032;
	localparam logic [12:0] LIMIT_OFFSET_MA = 13'h0032;

	// Cycles after reset release before the cell count pin is trusted
	localparam logic [2:0] SETTLE_CYCLES = 3'h4;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic adapter_present;
		logic limit_pin_low;
		logic limit_pin_above_4v;
		logic batt_below_floor;
		logic charging;
		logic supplementing;
		logic input_over_limit;
		logic input_under_voltage;
		logic [1:0] cell_count;
	} pin_in_t;

	typedef struct packed {
		logic high_impedance_state;
		logic switch_linear;
		logic switch_full_on;
		logic sys_above_batt_160mv;
		logic charge_throttle;
		logic limit_pin_enable;
	} regulation_t;

endpackage

// ---- verification/charger_regs_assertions.sv ----
module charger_regs_checker (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [7:0] cmd_in,
	input wire logic [15:0] wr_data_in,
	input wire logic wr_strobe_in,
	input wire logic rd_strobe_in,
	input wire charger_regs_pkg::pin_in_t pins_in,
	input wire logic [15:0] rd_data_out,
	input wire logic rd_valid_out,
	input wire logic [15:0] floor_voltage_out,
	input wire logic [12:0] input_ceiling_ma_out,
	input wire charger_regs_pkg::regulation_t regulation_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	// ****
	// Checks
	// ****
	sequence s_floor_wr;
		wr_strobe_in && cmd_in == 8'h3E;
	endsequence
	sequence s_floor_good;
		wr_data_in[15:14] == 2'h0 && wr_data_in[13:8] >= 6'h04;
	endsequence
	property p_floor_store;
		s_floor_wr ##0 s_floor_good |=> floor_voltage_out == {2'h0, $past(wr_data_in[13:8]), 8'h00};
	endproperty
	a_floor_store: assert property (p_floor_store) else $error("floor write lost");
	property p_floor_drop;
		s_floor_wr ##0 !(wr_data_in[15:14] == 2'h0 && wr_data_in[13:8] >= 6'h04)
			|=> $stable(floor_voltage_out);
	endproperty
	a_floor_drop: assert property (p_floor_drop) else $error("bad floor write taken");
	property p_floor_shape;
		floor_voltage_out[7:0] == 8'h00 && floor_voltage_out[15:14] == 2'h0;
	endproperty
	a_floor_shape: assert property (p_floor_shape) else $error("floor spare bits set");
	property p_rd_valid;
		rd_valid_out == $past(rd_strobe_in);
	endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("read valid mistimed");
	property p_rd_data;
		rd_strobe_in && cmd_in == 8'h3E |=> rd_data_out == $past(floor_voltage_out);
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("floor readback wrong");
	property p_ceiling;
		wr_strobe_in && cmd_in == 8'h3F && !wr_data_in[15]
			|=> ##1 input_ceiling_ma_out == 13'h0032 * $past(wr_data_in[14:8], 2) + 13'h0032;
	endproperty
	a_ceiling: assert property (p_ceiling) else $error("ceiling wrong");
	property p_throttle;
		(pins_in.input_over_limit || pins_in.input_under_voltage)[*8] |-> regulation_out.charge_throttle;
	endproperty
	a_throttle: assert property (p_throttle) else $error("no throttle");
	property p_pin_off;
		pins_in.limit_pin_above_4v[*8] |-> !regulation_out.limit_pin_enable;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("limit pin still used");
	property p_hiz_pin;
		(pins_in.limit_pin_low && !pins_in.limit_pin_above_4v)[*8] ##0 regulation_out.limit_pin_enable
			|-> regulation_out.high_impedance_state;
	endproperty
	a_hiz_pin: assert property (p_hiz_pin) else $error("pin low without hiz");
	// Reset value of the regulation outputs is all zero, so skip the first edge
	property p_path;
		!$past(rst_in) |-> !(regulation_out.switch_linear && regulation_out.switch_full_on)
			&& regulation_out.sys_above_batt_160mv
			== !(regulation_out.switch_linear || regulation_out.switch_full_on);
	endproperty
	a_path: assert property (p_path) else $error("switch modes clash");
endmodule // charger_regs_checker

// ---- verification/smbus_host_model.sv ----
module smbus_host_model (
	input wire logic clk_sys_in,
	input wire logic rd_valid_in,
	input wire logic [15:0] rd_data_in,
	output logic [7:0] cmd_out,
	output logic [15:0] wr_data_out,
	output logic wr_strobe_out,
	output logic rd_strobe_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{cmd_out, wr_data_out, wr_strobe_out, rd_strobe_out} = '0;
	end
	// ****
	// Word transfers, idle bus shows inverse so stale data never looks valid
	// ****
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge clk_sys_in) #1;
		{cmd_out, wr_data_out, wr_strobe_out} = {c, d, 1'h1};
		@(posedge clk_sys_in) #1;
		{cmd_out, wr_data_out, wr_strobe_out} = {~c, ~d, 1'h0};
	endtask
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		@(posedge clk_sys_in) #1;
		{cmd_out, rd_strobe_out} = {c, 1'h1};
		@(posedge clk_sys_in) #1;
		{cmd_out, rd_strobe_out} = {~c, 1'h0};
		d = rd_valid_in ? rd_data_in : 16'hXXXX;
	endtask
endmodule // smbus_host_model

// ---- verification/charger_sysmin_input_limit_regs_bench.sv ----
bind charger_sysmin_input_limit_regs charger_regs_checker u_charger_regs_checker (.clk_sys_in,
	.rst_in, .cmd_in, .wr_data_in, .wr_strobe_in, .rd_strobe_in, .pins_in, .rd_data_out,
	.rd_valid_out, .floor_voltage_out, .input_ceiling_ma_out, .regulation_out);
module charger_sysmin_input_limit_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'h0;
	logic rst_in = 1'h1;
	logic [7:0] cmd;
	logic [15:0] wd, rdata, fl_out;
	logic ws, rs, rv;
	logic [12:0] ceil_ma;
	charger_regs_pkg::pin_in_t pins = '0;
	charger_regs_pkg::regulation_t reg_o;
	int n_errors = 0;
	int check_count = 0;
	always #2.5 clk_sys_in = ~clk_sys_in;
	smbus_host_model u_host (.clk_sys_in, .rd_valid_in(rv), .rd_data_in(rdata), .cmd_out(cmd),
		.wr_data_out(wd), .wr_strobe_out(ws), .rd_strobe_out(rs));
	charger_sysmin_input_limit_regs u_charger_sysmin_input_limit_regs (.clk_sys_in, .rst_in,
		.cmd_in(cmd), .wr_data_in(wd), .wr_strobe_in(ws), .rd_strobe_in(rs), .pins_in(pins),
		.rd_data_out(rdata), .rd_valid_out(rv), .floor_voltage_out(fl_out),
		.input_ceiling_ma_out(ceil_ma), .regulation_out(reg_o));
	// ****
	// Helpers
	// ****
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
		logic [15:0] d;
		u_host.rd(c, d);
		chk("read", e, d);
	endtask
	// Pins are filtered, so every pin step waits out the synchroniser
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset;
		logic [15:0] fl [4] = '{16'h0E00, 16'h1800, 16'h2400, 16'h3000};
		for (int c = 0; c < 4; c++) begin
			pins.cell_count = 2'(c);
			rst_in = 1'h1;
			cyc(4);
			rst_in = 1'h0;
			cyc(5);
			rdchk(8'h3E, fl[c]);
			rdchk(8'h3F, 16'h4100);
			rdchk(8'h12, 16'h0004);
			chk("ceiling", 16'h0CE4, 16'(ceil_ma));
		end
		$display("reset test done");
	endtask
	task automatic t_floor;
		logic [15:0] w [6] = '{16'h0400, 16'h3FFF, 16'h20FF, 16'h0300, 16'h4800, 16'h8800};
		logic [15:0] e [6] = '{16'h0400, 16'h3F00, 16'h2000, 16'h2000, 16'h2000, 16'h2000};
		for (int i = 0; i < 6; i++) begin
			u_host.wr(8'h3E, w[i]);
			rdchk(8'h3E, e[i]);
		end
		chk("floor", 16'h2000, fl_out);
		$display("floor test done");
	endtask
	task automatic t_limit;
		pins.adapter_present = 1'h1;
		u_host.wr(8'h3F, 16'h0000);
		cyc(2);
		chk("ceiling", 16'h0032, 16'(ceil_ma));
		u_host.wr(8'h3F, 16'h7F00);
		u_host.wr(8'h3F, 16'h8100);
		cyc(2);
		chk("ceiling", 16'h1900, 16'(ceil_ma));
		pins.adapter_present = 1'h0;
		cyc(8);
		rdchk(8'h3F, 16'h4100);
		chk("ceiling", 16'h0CE4, 16'(ceil_ma));
		$display("limit test done");
	endtask
	task automatic t_hiz;
		u_host.wr(8'h32, 16'h8000);
		u_host.wr(8'h12, 16'h0000);
		u_host.wr(8'h30, 16'h0000);
		chk("hiz", 16'h0001, 16'(reg_o.high_impedance_state));
		rdchk(8'h15, 16'h0000);
		u_host.wr(8'h14, 16'h0400);
		u_host.wr(8'h3F, 16'h0500);
		rdchk(8'h30, 16'h0000);
		pins.limit_pin_low = 1'h1;
		u_host.wr(8'h32, 16'h0000);
		cyc(8);
		chk("hiz", 16'h0001, 16'(reg_o.high_impedance_state));
		u_host.wr(8'h31, 16'h0080);
		cyc(2);
		chk("hiz", 16'h0000, 16'(reg_o.high_impedance_state));
		u_host.wr(8'h31, 16'h0000);
		pins.limit_pin_above_4v = 1'h1;
		cyc(8);
		chk("hiz", 16'h0000, 16'(reg_o.high_impedance_state));
		pins.limit_pin_low = 1'h0;
		pins.limit_pin_above_4v = 1'h0;
		$display("hiz test done");
	endtask
	task automatic t_reg;
		u_host.wr(8'h12, 16'h0004);
		pins.batt_below_floor = 1'h1;
		pins.charging = 1'h1;
		cyc(8);
		chk("path", 16'h0011, 16'(reg_o));
		{pins.batt_below_floor, pins.charging, pins.supplementing} = 3'h1;
		cyc(8);
		chk("path", 16'h0009, 16'(reg_o));
		{pins.supplementing, pins.input_over_limit} = 2'h1;
		cyc(8);
		chk("path", 16'h0007, 16'(reg_o));
		{pins.input_over_limit, pins.input_under_voltage} = 2'h1;
		cyc(8);
		chk("path", 16'h0007, 16'(reg_o));
		$display("regulation test done");
	endtask
	initial begin
		t_reset();
		t_floor();
		t_limit();
		t_hiz();
		t_reg();
		print_verdict();
	end
endmodule // charger_sysmin_input_limit_regs_bench
